// file: hdl/ssp_pkg.sv
// shared constants for the sync serial shift port
package ssp_pkg;
  // register byte addresses (word index times four)
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DATA   = 4'h8;
  localparam logic [3:0] ADDR_IRQ    = 4'hc;
  // control register field positions
  localparam int CTL_RATE_LO  = 0;
  localparam int CTL_RATE_HI  = 1;
  localparam int CTL_PORT_SEL = 2;
  localparam int CTL_CLK_CFG  = 3;
  localparam int CTL_OUT_CFG  = 4;
  localparam int CTL_IDLE_LVL = 5;
  localparam int CTL_PHASE    = 6;
  localparam int CTL_IRQ_EN   = 7;
  // interrupt field positions
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ABORT = 1;
  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET  = 2'h0;
  // half periods of the shift clock less one, in instruction cycles
  localparam logic [1:0] HALF_FAST = 2'h0;
  localparam logic [1:0] HALF_MID  = 2'h1;
  localparam logic [1:0] HALF_SLOW = 2'h3;
  // bits per transfer
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  // a write to the status register with this bit starts or stops
  localparam int STAT_BUSY = 0;
  // transfer states
  typedef enum logic [1:0]
  {
    SSP_IDLE  = 2'b00,
    SSP_SHIFT = 2'b01
  } ssp_state_t;
endpackage

// file: hdl/ssp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ssp_sync
#(
  parameter int WIDTH = 2
)
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // asynchronous level in, synchronous level out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } ssp_sync_st_t;

  ssp_sync_st_t st_q;
  ssp_sync_st_t st_d;

  // first stage feeds only the second
  always_comb
  begin
    st_d      = st_q;
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
  end

  // state register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.sync;
endmodule

// file: hdl/ssp_top.sv
// eight-bit synchronous serial shift port with avalon register slave
`timescale 1ns/1ps
module ssp_top
#(
  parameter int BITS = 8
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // instruction cycle enable
  input  wire logic        cycle_en_in,
  // serial pins
  input  wire logic        serial_in_in,
  output logic             serial_out_out,
  output logic             serial_out_oe_out,
  input  wire logic        shift_clock_in,
  output logic             shift_clock_out,
  output logic             shift_clock_oe_out,
  // interrupt
  output logic             irq_out
);
  typedef struct packed
  {
    ssp_pkg::ssp_state_t state;
    logic [7:0]          ctrl;
    logic [BITS-1:0]     sreg;
    logic [3:0]          count;
    logic [1:0]          div;
    logic                sck;
    logic                sck_prev;
    logic                sdo;
    logic [1:0]          irq_stat;
    logic [1:0]          irq_mask;
    logic [31:0]         rdata;
    logic                ack;
    logic                irq;
  } ssp_st_t;

  ssp_st_t    st_q;
  ssp_st_t    st_d;
  logic [1:0] pins_sync;

  // pin inputs pass two flops first
  ssp_sync #(.WIDTH(2)) u_sync
  (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({serial_in_in, shift_clock_in}),
    .sync_out (pins_sync)
  );

  logic       port_on;
  logic       master;
  logic       alt_phase;
  logic       idle_lvl;
  logic       clk_now;
  logic       rise;
  logic       fall;
  logic       sample_edge;
  logic       shift_edge;
  logic [1:0] half;
  logic       wr_hit;
  logic       rd_hit;

  // decoded controls
  always_comb
  begin
    port_on   = st_q.ctrl[ssp_pkg::CTL_PORT_SEL];
    master    = st_q.ctrl[ssp_pkg::CTL_CLK_CFG];
    alt_phase = st_q.ctrl[ssp_pkg::CTL_PHASE];
    idle_lvl  = st_q.ctrl[ssp_pkg::CTL_IDLE_LVL];
    // rate select: high bit forces the slowest rate
    if (st_q.ctrl[ssp_pkg::CTL_RATE_HI])
    begin
      half = ssp_pkg::HALF_SLOW;
    end
    else if (st_q.ctrl[ssp_pkg::CTL_RATE_LO])
    begin
      half = ssp_pkg::HALF_MID;
    end
    else
    begin
      half = ssp_pkg::HALF_FAST;
    end
    // clock seen by the shifter, master or slave
    clk_now     = master ? st_q.sck : pins_sync[0];
    rise        = clk_now & ~st_q.sck_prev;
    fall        = ~clk_now & st_q.sck_prev;
    sample_edge = alt_phase ? fall : rise;
    shift_edge  = alt_phase ? rise : fall;
    // single-cycle answer, so waitrequest only drops on the ack cycle
    wr_hit = avs_write_in & ~st_q.ack;
    rd_hit = avs_read_in & ~st_q.ack;
  end

  logic [BITS-1:0] sreg_v;
  logic [1:0]      irq_set;

  // next-state logic
  always_comb
  begin
    st_d          = st_q;
    sreg_v        = st_q.sreg;
    irq_set       = 2'h0;
    st_d.ack      = (avs_read_in | avs_write_in) & ~st_q.ack;
    st_d.sck_prev = clk_now;
    // shifting: sample input, move data out msb first
    if (st_q.state == ssp_pkg::SSP_SHIFT)
    begin
      // master divider runs on instruction cycle enables
      if (master && cycle_en_in)
      begin
        if (st_q.div == half)
        begin
          st_d.div = 2'h0;
          st_d.sck = ~st_q.sck;
        end
        else
        begin
          st_d.div = st_q.div + 2'h1;
        end
      end
      if (sample_edge)
      begin
        sreg_v     = {st_q.sreg[BITS-2:0], pins_sync[1]};
        st_d.sreg  = sreg_v;
        st_d.count = st_q.count + 4'h1;
      end
      if (shift_edge)
      begin
        st_d.sdo = st_q.sreg[BITS-1];
      end
      // eight samples in and clock back at idle: stop here, so no
      // ninth edge leaks out for any phase or idle level
      if ((sample_edge | shift_edge) && clk_now == idle_lvl
          && st_d.count == ssp_pkg::BITS_PER_XFER)
      begin
        st_d.state = ssp_pkg::SSP_IDLE;
        st_d.sck   = idle_lvl;
        irq_set[ssp_pkg::IRQ_DONE] = 1'b1;
      end
    end
    else
    begin
      st_d.sck = idle_lvl;
      st_d.div = 2'h0;
      st_d.sdo = st_q.sreg[BITS-1];
    end
    // register writes
    if (wr_hit)
    begin
      case (avs_address_in)
        ssp_pkg::ADDR_CTRL:
        begin
          st_d.ctrl = avs_writedata_in[7:0];
        end
        ssp_pkg::ADDR_STATUS:
        begin
          if (avs_writedata_in[ssp_pkg::STAT_BUSY] && port_on)
          begin
            st_d.state = ssp_pkg::SSP_SHIFT;
            st_d.count = 4'h0;
          end
          else if (!avs_writedata_in[ssp_pkg::STAT_BUSY]
                   && st_q.state == ssp_pkg::SSP_SHIFT)
          begin
            st_d.state = ssp_pkg::SSP_IDLE;
            st_d.sck   = idle_lvl;
            irq_set[ssp_pkg::IRQ_ABORT] = 1'b1;
          end
        end
        ssp_pkg::ADDR_DATA:
        begin
          st_d.sreg = avs_writedata_in[BITS-1:0];
        end
        ssp_pkg::ADDR_IRQ:
        begin
          st_d.irq_mask = avs_writedata_in[1:0];
        end
        default:
        begin
          st_d.irq_mask = st_q.irq_mask;
        end
      endcase
    end
    // port select off also ends a transfer
    if (!port_on)
    begin
      st_d.state = ssp_pkg::SSP_IDLE;
    end
    // register reads; irq register read clears sticky bits, set wins
    st_d.rdata = 32'h0000_0000;
    if (rd_hit)
    begin
      case (avs_address_in)
        ssp_pkg::ADDR_CTRL:
        begin
          st_d.rdata = {24'h00_0000, st_q.ctrl};
        end
        ssp_pkg::ADDR_STATUS:
        begin
          st_d.rdata = {27'h000_0000, st_q.count,
                        st_q.state == ssp_pkg::SSP_SHIFT};
        end
        ssp_pkg::ADDR_DATA:
        begin
          st_d.rdata = {24'h00_0000, st_q.sreg};
        end
        ssp_pkg::ADDR_IRQ:
        begin
          st_d.rdata    = {28'h000_0000, st_q.irq_mask,
                           st_q.irq_stat};
          st_d.irq_stat = 2'h0;
        end
        default:
        begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end
    // an event in the clearing cycle is not lost
    st_d.irq_stat = st_d.irq_stat | irq_set;
    // done irq only when its enable and mask allow
    st_d.irq = (st_q.irq_stat[ssp_pkg::IRQ_DONE]
                & st_q.ctrl[ssp_pkg::CTL_IRQ_EN]
                & st_q.irq_mask[ssp_pkg::IRQ_DONE])
             | (st_q.irq_stat[ssp_pkg::IRQ_ABORT]
                & st_q.irq_mask[ssp_pkg::IRQ_ABORT]);
  end

  // state register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_q          <= '0;
      st_q.state    <= ssp_pkg::SSP_IDLE;
      st_q.ctrl     <= ssp_pkg::CTRL_RESET;
      st_q.sreg     <= ssp_pkg::DATA_RESET;
      st_q.irq_stat <= ssp_pkg::IRQ_RESET;
      st_q.irq_mask <= ssp_pkg::IRQ_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // pin drivers, registered outputs
  logic sck_pin_q;
  logic sck_oe_q;
  logic so_oe_q;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sck_pin_q <= 1'b0;
      sck_oe_q  <= 1'b0;
      so_oe_q   <= 1'b0;
    end
    else
    begin
      sck_pin_q <= st_d.sck;
      sck_oe_q  <= st_d.ctrl[ssp_pkg::CTL_PORT_SEL]
                   & st_d.ctrl[ssp_pkg::CTL_CLK_CFG];
      so_oe_q   <= st_d.ctrl[ssp_pkg::CTL_PORT_SEL]
                   & st_d.ctrl[ssp_pkg::CTL_OUT_CFG];
    end
  end

  assign serial_out_out      = st_q.sdo;
  assign serial_out_oe_out   = so_oe_q;
  assign shift_clock_out     = sck_pin_q;
  assign shift_clock_oe_out  = sck_oe_q;
  assign avs_readdata_out    = st_q.rdata;
  assign avs_waitrequest_out = ~st_q.ack;
  assign irq_out             = st_q.irq;

  // busy clears once eight samples are in and the clock sits idle
  a_busy_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q.state == ssp_pkg::SSP_SHIFT && st_q.count
     == ssp_pkg::BITS_PER_XFER && clk_now == idle_lvl && !wr_hit)
    |=> st_q.state == ssp_pkg::SSP_IDLE)
    else $error("busy did not clear after eight bits");

  a_count_bound: assert property (@(posedge clk_in) disable iff (rst_in)
    st_q.count <= ssp_pkg::BITS_PER_XFER)
    else $error("bit count passed eight");

  a_port_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    !port_on |=> st_q.state == ssp_pkg::SSP_IDLE)
    else $error("shifting without port select");

  a_done_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(st_q.irq_stat[ssp_pkg::IRQ_DONE]) |->
    st_q.count == ssp_pkg::BITS_PER_XFER)
    else $error("done flag without eight bits");

  a_abort_stop: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_hit && avs_address_in == ssp_pkg::ADDR_STATUS
     && !avs_writedata_in[0] && st_q.state == ssp_pkg::SSP_SHIFT)
    |=> st_q.state == ssp_pkg::SSP_IDLE)
    else $error("early clear did not stop shifting");

  a_msb_first: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q.state == ssp_pkg::SSP_SHIFT && sample_edge && !wr_hit)
    |=> st_q.sreg[0] == $past(pins_sync[1]))
    else $error("input bit did not enter at lsb");

  a_idle_clock: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q.state == ssp_pkg::SSP_IDLE && !wr_hit) [*2]
    |-> st_q.sck == idle_lvl)
    else $error("shift clock not at idle level");

  a_slave_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    (!master && st_q.state == ssp_pkg::SSP_SHIFT)
    |=> $stable(st_q.div))
    else $error("divider ran in slave mode");

  a_master_oe: assert property (@(posedge clk_in) disable iff (rst_in)
    (port_on && master && !wr_hit) ##1 !wr_hit
    |-> shift_clock_oe_out)
    else $error("master not driving shift clock");
endmodule

// file: tb/ssp_peer.sv
// link-side peer: slave on the device clock, master on its own
`timescale 1ns/1ps
module ssp_peer
(
  // device pins seen by the peer
  input  wire logic dev_clk_in,
  input  wire logic dev_clk_oe_in,
  input  wire logic dev_data_in,
  input  wire logic alt_phase_in,
  // pins driven by the peer
  output logic      peer_clk_out,
  output logic      peer_data_out
);
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  int         n_rx;
  logic       got_q;
  wire logic  line_w;
  // own clock only counts while the device listens
  assign line_w = dev_clk_oe_in ? dev_clk_in : peer_clk_out;
  initial
  begin
    peer_clk_out = 1'h0;
    peer_data_out = 1'h0;
  end
  // load a byte; its msb waits on the line before the first edge
  task automatic arm(input logic [7:0] b);
    tx_q = b;
    n_rx = 0;
    got_q = 1'h0;
    peer_data_out = b[7];
  endtask
  // eight pulses, clock stands low outside the frame
  task automatic run_master();
    #17;
    repeat (8)
    begin
      #200 peer_clk_out = 1'h1;
      #200 peer_clk_out = 1'h0;
    end
  endtask
  // sample on one edge, shift on the other, as phase selects
  always @(line_w)
  begin
    if ((line_w ^ alt_phase_in) === 1'h1 && n_rx < 8)
    begin
      rx_q = {rx_q[6:0], dev_data_in};
      n_rx++;
      got_q = 1'h1;
    end
    else if (got_q)
    begin
      tx_q = tx_q << 1;
      got_q = 1'h0;
      // after the byte the line no longer holds the last bit
      peer_data_out = (n_rx < 8) ? tx_q[7] : ~peer_data_out;
    end
  end
endmodule

// file: tb/ssp_top_tb.sv
// self-checking bench for the sync serial shift port
`timescale 1ns/1ps
module ssp_top_tb;
  // design pins and bench counters
  logic        clk_in = 1'h0;
  logic        rst_in = 1'h1;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'h0;
  logic        avs_write_in = 1'h0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        cycle_en_in = 1'h1;
  logic        serial_in_in;
  logic        serial_out_out;
  logic        serial_out_oe_out;
  logic        shift_clock_in;
  logic        shift_clock_out;
  logic        shift_clock_oe_out;
  logic        irq_out;
  logic        alt_q = 1'h0;
  int          checks = 0;
  int          n_mismatch = 0;
  // 20 mhz clock
  always #25 clk_in = ~clk_in;
  ssp_top i_dut
  (
    .clk_in              (clk_in),
    .rst_in              (rst_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .cycle_en_in         (cycle_en_in),
    .serial_in_in        (serial_in_in),
    .serial_out_out      (serial_out_out),
    .serial_out_oe_out   (serial_out_oe_out),
    .shift_clock_in      (shift_clock_in),
    .shift_clock_out     (shift_clock_out),
    .shift_clock_oe_out  (shift_clock_oe_out),
    .irq_out             (irq_out)
  );
  ssp_peer i_peer
  (
    .dev_clk_in    (shift_clock_out),
    .dev_clk_oe_in (shift_clock_oe_out),
    .dev_data_in   (serial_out_out),
    .alt_phase_in  (alt_q),
    .peer_clk_out  (shift_clock_in),
    .peer_data_out (serial_in_in)
  );
  // verdict
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= ~w;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'h0 && n < 100)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 100)
      n_mismatch++;
    q = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    bus(1'h0, a, 32'h0, q);
  endtask
  // poll busy with a bound
  task automatic wait_idle();
    int          n;
    logic [31:0] q;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'h0 && n < 300)
    begin
      rd(ssp_pkg::ADDR_STATUS, q);
      n++;
    end
    if (n >= 300)
      n_mismatch++;
  endtask
  task automatic s_reset();
    logic [31:0] q;
    chk({29'h0, serial_out_oe_out, shift_clock_oe_out, irq_out},
        32'h0);
    rd(ssp_pkg::ADDR_CTRL, q);
    chk(q, {24'h0, ssp_pkg::CTRL_RESET});
    rd(ssp_pkg::ADDR_DATA, q);
    chk(q, 32'h0);
    wr(4'h1, 32'hff);
    rd(4'h1, q);
    chk(q, 32'h0);
    rd(ssp_pkg::ADDR_IRQ, q);
    chk(q, 32'h0);
  endtask
  // busy is ignored while the port is not selected
  task automatic s_refuse();
    logic [31:0] q;
    wr(ssp_pkg::ADDR_CTRL, 32'h18);
    wr(ssp_pkg::ADDR_STATUS, 32'h1);
    rd(ssp_pkg::ADDR_STATUS, q);
    chk(q & 32'h1, 32'h0);
    chk({30'h0, serial_out_oe_out, shift_clock_oe_out}, 32'h0);
  endtask
  // master byte; data only judged at rates the pin synchroniser allows
  task automatic s_master(input logic [1:0] r, input logic alt,
                          input logic msk, input int per);
    logic [31:0] q;
    int          n;
    int          e;
    int          t0;
    logic        last;
    wr(ssp_pkg::ADDR_CTRL, {24'h0, 1'h1, alt, 4'h7, r});
    alt_q <= alt;
    wr(ssp_pkg::ADDR_IRQ, {31'h0, msk});
    wr(ssp_pkg::ADDR_DATA, 32'ha5);
    i_peer.arm(8'h3c);
    wr(ssp_pkg::ADDR_STATUS, 32'h1);
    e = 0;
    t0 = 0;
    last = shift_clock_out;
    for (n = 0; n < 300 && e < 2; n++)
    begin
      @(posedge clk_in);
      if (shift_clock_out === 1'h1 && last === 1'h0)
      begin
        e++;
        t0 = n - t0;
      end
      last = shift_clock_out;
    end
    chk(32'(t0), 32'(per));
    wait_idle();
    rd(ssp_pkg::ADDR_DATA, q);
    if (r != 2'h0)
      chk(q, 32'h3c);
    if (r != 2'h0)
      chk(32'(i_peer.rx_q), 32'ha5);
    chk({31'h0, irq_out}, {31'h0, msk});
    rd(ssp_pkg::ADDR_IRQ, q);
    chk(q & 32'h3, 32'h1);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
  endtask
  task automatic s_abort();
    logic [31:0] q;
    wr(ssp_pkg::ADDR_CTRL, 32'h9f);
    wr(ssp_pkg::ADDR_IRQ, 32'h2);
    wr(ssp_pkg::ADDR_DATA, 32'h5a);
    i_peer.arm(8'h00);
    wr(ssp_pkg::ADDR_STATUS, 32'h1);
    repeat (12) @(posedge clk_in);
    wr(ssp_pkg::ADDR_STATUS, 32'h0);
    rd(ssp_pkg::ADDR_STATUS, q);
    chk(q & 32'h1, 32'h0);
    repeat (80) @(posedge clk_in);
    chk(32'(i_peer.n_rx < 8), 32'h1);
    chk({31'h0, irq_out}, 32'h1);
    rd(ssp_pkg::ADDR_IRQ, q);
    chk(q & 32'h3, 32'h2);
  endtask
  // slave byte on the peer's 400 ns clock, then pin routing
  task automatic s_slave();
    logic [31:0] q;
    wr(ssp_pkg::ADDR_CTRL, 32'h94);
    alt_q <= 1'h0;
    wr(ssp_pkg::ADDR_IRQ, 32'h1);
    wr(ssp_pkg::ADDR_DATA, 32'h69);
    i_peer.arm(8'hc3);
    wr(ssp_pkg::ADDR_STATUS, 32'h1);
    chk({30'h0, shift_clock_oe_out, serial_out_oe_out}, 32'h1);
    i_peer.run_master();
    // back onto the bench clock before the next bus request
    @(posedge clk_in);
    wait_idle();
    rd(ssp_pkg::ADDR_DATA, q);
    chk(q, 32'hc3);
    chk(32'(i_peer.rx_q), 32'h69);
    chk({31'h0, irq_out}, 32'h1);
    rd(ssp_pkg::ADDR_IRQ, q);
    chk(q & 32'h3, 32'h1);
    wr(ssp_pkg::ADDR_CTRL, 32'h2c);
    repeat (2) @(posedge clk_in);
    chk({29'h0, shift_clock_oe_out, shift_clock_out, serial_out_oe_out},
        32'h6);
  endtask
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'h0;
    @(posedge clk_in);
    s_reset();
    s_refuse();
    s_master(2'h0, 1'h0, 1'h0, 2);
    s_master(2'h1, 1'h0, 1'h1, 4);
    s_master(2'h2, 1'h0, 1'h1, 8);
    s_master(2'h3, 1'h1, 1'h1, 8);
    s_abort();
    s_slave();
    test_done();
  end
  // hang guard, far beyond the expected run
  initial
  begin
    #2000000;
    n_mismatch++;
    test_done();
  end
endmodule
